// ### rtl/mcs_pkg.sv
// shared constants and types of the module control and status block
package mcs_pkg;

    // --------------------
    // clock and timing
    // --------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned T_INIT_MS     = 300;
    localparam int unsigned T_SERIAL_MS   = 300;
    localparam int unsigned T_DATA_MS     = 1000;
    localparam int unsigned T_RESET_US    = 10;
    // longest times round down, least times round up
    localparam int unsigned T_INIT_CYC    = T_INIT_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned T_SERIAL_CYC  = T_SERIAL_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned T_DATA_CYC    = T_DATA_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned RESET_HOLD_CYC =
        (T_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // input debounce, well inside the reporting budgets
    localparam int unsigned FAULT_FILT_CYC = 100;
    localparam int unsigned LOS_FILT_CYC   = 1000;

    // --------------------
    // two-wire addressing and the soft control/status byte
    // --------------------
    localparam logic [6:0] ID_ADDR      = 7'h50;
    localparam logic [6:0] DIAG_ADDR    = 7'h51;
    localparam logic [7:0] CS_OFFSET    = 8'h6E;
    localparam logic [7:0] CS_RESET     = 8'h00;
    localparam int unsigned SOFT_DIS_BIT = 6;
    localparam int unsigned FAULT_BIT    = 2;
    localparam int unsigned LOS_BIT      = 1;
    localparam int unsigned READY_BIT    = 0;
    localparam logic [3:0] MAX_WR_BYTES = 4'h8;

    // --------------------
    // types
    // --------------------
    typedef struct packed {
        logic bus_ready;
        logic soft_dis;
        logic fault;
        logic lost;
        logic data_ready;
    } ctl_stat_s;

    typedef enum logic [1:0] {
        LS_INIT  = 2'h0,
        LS_RUN   = 2'h1,
        LS_FAULT = 2'h3
    } laser_state_e;

    typedef enum logic [2:0] {
        TS_IDLE  = 3'h0,
        TS_ADDR  = 3'h1,
        TS_ACK   = 3'h3,
        TS_WDATA = 3'h2,
        TS_RDATA = 3'h6,
        TS_RACK  = 3'h7
    } twi_state_e;

endpackage

// ### rtl/sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    always_ff @(posedge clk_in) begin
        s1_q <= d_in;
        s2_q <= s1_q;
    end

    assign q_out = s2_q;
endmodule

// ### rtl/stable_filter.sv
// synchronised input that must hold a new level for a set time
`timescale 1ns/1ps
module stable_filter #(
    parameter int unsigned CYC  = 100,
    parameter bit          INIT = 1'h0
) (
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic raw_in,
    output logic      level_out
);
    localparam int CW = $clog2(CYC + 1);

    logic          raw_s;
    logic [CW-1:0] cnt_q;
    logic          level_q;

    sync2 #(.W(1)) u_sync (
        .clk_in (clk_in),
        .d_in   (raw_in),
        .q_out  (raw_s)
    );

    wire differ  = raw_s != level_q;
    wire settled = cnt_q == CW'(CYC - 1);

    always_ff @(posedge clk_in) begin
        if (reset_in || !differ) begin
            cnt_q <= '0;
        end else if (settled) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            level_q <= INIT;
        end else if (differ && settled) begin
            level_q <= raw_s;
        end
    end

    assign level_out = level_q;
endmodule

// ### rtl/module_ctl_status.sv
// laser control, fault latch, loss of signal and two-wire status byte
`timescale 1ns/1ps

// Contract
// - disable pin high darkens laser within 10us
// - disable pin low restores output within 1ms
// - initialization clears fault within 300ms
// - fault pin asserts within 1ms of fault
// - loss pin follows optical input within 100us
// - soft disable bit darkens laser within 100ms
// - soft fault bit sets within 100ms
// - soft loss bit follows input within 100ms
// - data-ready bit set within 1000ms of power-on
// - two-wire bus serves both addresses by 300ms
// - write commits within 40ms or 80ms
// - bus at most 400kHz, stretching tolerated
module module_ctl_status #(
    parameter int unsigned INIT_CYCLES   = mcs_pkg::T_INIT_CYC,
    parameter int unsigned SERIAL_CYCLES = mcs_pkg::T_SERIAL_CYC,
    parameter int unsigned DATA_CYCLES   = mcs_pkg::T_DATA_CYC
) (
    input  wire logic          ref_clk_in,
    input  wire logic          reset_in,
    input  wire logic          link_clk_in,
    input  wire logic          laser_disable_in,
    input  wire logic          fault_detect_in,
    input  wire logic          signal_detect_in,
    input  wire logic          scl_in,
    output logic               scl_out,
    output logic               scl_oe_out,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe_out,
    output logic               laser_enable_out,
    output logic               laser_fault_out,
    output logic               optical_input_lost_flag_out,
    output mcs_pkg::ctl_stat_s status_out
);
    import mcs_pkg::*;

    localparam int IW = $clog2(INIT_CYCLES + 1);
    localparam int PW = $clog2(DATA_CYCLES + 1);
    localparam int HW = $clog2(RESET_HOLD_CYC + 1);

    // --------------------
    // read data of the two-wire slave
    // --------------------
    function automatic logic [7:0] rd_byte(
        input logic      diag,
        input logic [7:0] ptr,
        input ctl_stat_s s
    );
        logic [7:0] b;
        b = CS_RESET;
        b[SOFT_DIS_BIT] = s.soft_dis;
        b[FAULT_BIT]    = s.fault;
        b[LOS_BIT]      = s.lost;
        b[READY_BIT]    = s.data_ready;
        // identification memory is not held here; it reads as zero
        return (diag && ptr == CS_OFFSET) ? b : 8'h00;
    endfunction

    // --------------------
    // input conditioning
    // --------------------
    logic dis_s;
    logic fault_f;
    logic sig_ok;

    sync2 #(.W(1)) u_dis_sync (
        .clk_in (ref_clk_in),
        .d_in   (laser_disable_in),
        .q_out  (dis_s)
    );

    stable_filter #(.CYC(FAULT_FILT_CYC), .INIT(1'h0)) u_fault_filt (
        .clk_in    (ref_clk_in),
        .reset_in  (reset_in),
        .raw_in    (fault_detect_in),
        .level_out (fault_f)
    );

    // starts as lost until light has been seen for the filter time
    stable_filter #(.CYC(LOS_FILT_CYC), .INIT(1'h0)) u_sig_filt (
        .clk_in    (ref_clk_in),
        .reset_in  (reset_in),
        .raw_in    (signal_detect_in),
        .level_out (sig_ok)
    );

    // --------------------
    // laser state machine
    // --------------------
    laser_state_e  ls_q;
    laser_state_e  ls_d;
    logic [IW-1:0] init_cnt_q;
    logic [HW-1:0] hold_cnt_q;
    logic          soft_dis_q;
    logic          laser_en_q;
    logic          fault_q;
    logic          lost_q;

    wire init_done = init_cnt_q >= IW'(INIT_CYCLES / 2);
    wire hold_ok   = hold_cnt_q >= HW'(RESET_HOLD_CYC);
    wire fault_hit = laser_en_q && fault_f;

    always_comb begin
        ls_d = ls_q;
        case (ls_q)
            LS_INIT:  if (init_done && !dis_s) ls_d = LS_RUN;
            LS_RUN:   if (fault_hit) ls_d = LS_FAULT;
            LS_FAULT: if (!dis_s && hold_ok) ls_d = LS_INIT;
            default:  ls_d = LS_INIT;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ls_q <= LS_INIT;
        end else begin
            ls_q <= ls_d;
        end
    end

    // init restarts while the pin is high, so it is timed from the fall
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || ls_q != LS_INIT || dis_s) begin
            init_cnt_q <= '0;
        end else if (!init_done) begin
            init_cnt_q <= init_cnt_q + IW'(1);
        end
    end

    // a short pulse on the pin does not clear a latched fault
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || ls_q != LS_FAULT || !dis_s) begin
            hold_cnt_q <= '0;
        end else if (!hold_ok) begin
            hold_cnt_q <= hold_cnt_q + HW'(1);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            laser_en_q <= 1'h0;
            fault_q    <= 1'h0;
            lost_q     <= 1'h1;
        end else begin
            laser_en_q <= ls_d == LS_RUN && !dis_s && !soft_dis_q;
            fault_q    <= ls_d == LS_FAULT;
            lost_q     <= !sig_ok;
        end
    end

    assign laser_enable_out            = laser_en_q;
    assign laser_fault_out             = fault_q;
    assign optical_input_lost_flag_out = lost_q;

    // --------------------
    // power-on readiness
    // --------------------
    logic [PW-1:0] pwr_cnt_q;
    logic          bus_ready_q;
    logic          data_ready_q;

    wire pwr_end = pwr_cnt_q == PW'(DATA_CYCLES - 1);

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            pwr_cnt_q <= '0;
        end else if (!pwr_end) begin
            pwr_cnt_q <= pwr_cnt_q + PW'(1);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            bus_ready_q  <= 1'h0;
            data_ready_q <= 1'h0;
        end else begin
            if (pwr_cnt_q >= PW'(SERIAL_CYCLES / 2)) bus_ready_q <= 1'h1;
            if (pwr_end) data_ready_q <= 1'h1;
        end
    end

    // --------------------
    // soft byte write arriving from the link domain
    // --------------------
    logic wr_req_q;
    logic wr_val_q;
    logic req_s;
    logic req_seen_q;

    sync2 #(.W(1)) u_req_sync (
        .clk_in (ref_clk_in),
        .d_in   (wr_req_q),
        .q_out  (req_s)
    );

    wire take = req_s != req_seen_q;

    // wr_val_q stands still until the acknowledge gets back
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            req_seen_q <= 1'h0;
            soft_dis_q <= CS_RESET[SOFT_DIS_BIT];
        end else if (take) begin
            req_seen_q <= req_s;
            soft_dis_q <= wr_val_q;
        end
    end

    ctl_stat_s stat_q;
    ctl_stat_s stat_d;

    assign stat_d.bus_ready  = bus_ready_q;
    assign stat_d.soft_dis   = soft_dis_q;
    assign stat_d.fault      = fault_q;
    assign stat_d.lost       = lost_q;
    assign stat_d.data_ready = data_ready_q;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    assign status_out = stat_q;

    // --------------------
    // link domain: reset, pins and crossings
    // --------------------
    logic      lrst;
    logic      ack_l;
    logic [1:0] pin_s;
    logic [4:0] lstat_v;
    ctl_stat_s lstat;

    sync2 #(.W(1)) u_lrst_sync (
        .clk_in (link_clk_in),
        .d_in   (reset_in),
        .q_out  (lrst)
    );

    sync2 #(.W(1)) u_ack_sync (
        .clk_in (link_clk_in),
        .d_in   (req_seen_q),
        .q_out  (ack_l)
    );

    sync2 #(.W(2)) u_pin_sync (
        .clk_in (link_clk_in),
        .d_in   ({scl_in, sda_in}),
        .q_out  (pin_s)
    );

    // independent flag levels, each may cross on its own
    sync2 #(.W(5)) u_stat_sync (
        .clk_in (link_clk_in),
        .d_in   (stat_q),
        .q_out  (lstat_v)
    );

    assign lstat = ctl_stat_s'(lstat_v);

    wire  scl_s = pin_s[1];
    wire  sda_s = pin_s[0];
    logic scl_p_q;
    logic sda_p_q;

    always_ff @(posedge link_clk_in) begin
        if (lrst) begin
            scl_p_q <= 1'h1;
            sda_p_q <= 1'h1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    wire start_c  = scl_s && scl_p_q && sda_p_q && !sda_s;
    wire stop_c   = scl_s && scl_p_q && !sda_p_q && sda_s;
    wire scl_rise = scl_s && !scl_p_q;
    wire scl_fall = !scl_s && scl_p_q;

    // --------------------
    // two-wire slave
    // --------------------
    twi_state_e ts_q;
    logic [7:0] sh_q;
    logic [3:0] bc_q;
    logic [7:0] ptr_q;
    logic [3:0] wcnt_q;
    logic       rw_q;
    logic       diag_q;
    logic       got_ptr_q;
    logic       wr_hit_q;
    logic       mack_q;
    logic       sda_oe_q;
    logic       scl_oe_q;

    wire [6:0] dev_a    = sh_q[7:1];
    wire       busy_l   = wr_req_q != ack_l;
    wire       hit_id   = dev_a == ID_ADDR;
    wire       hit_diag = dev_a == DIAG_ADDR;
    wire       addr_ok  = (hit_id || hit_diag) && lstat.bus_ready && !busy_l;
    wire       byte_end = scl_fall && bc_q == 4'h8;
    wire [7:0] rd_next  = rd_byte(diag_q, ptr_q, lstat);

    always_ff @(posedge link_clk_in) begin
        if (lrst) begin
            ts_q      <= TS_IDLE;
            sh_q      <= 8'h00;
            bc_q      <= 4'h0;
            ptr_q     <= 8'h00;
            wcnt_q    <= 4'h0;
            rw_q      <= 1'h0;
            diag_q    <= 1'h0;
            got_ptr_q <= 1'h0;
            wr_hit_q  <= 1'h0;
            wr_req_q  <= 1'h0;
            wr_val_q  <= CS_RESET[SOFT_DIS_BIT];
            mack_q    <= 1'h0;
            sda_oe_q  <= 1'h0;
            scl_oe_q  <= 1'h0;
        end else if (stop_c) begin
            ts_q      <= TS_IDLE;
            sda_oe_q  <= 1'h0;
            scl_oe_q  <= 1'h0;
            got_ptr_q <= 1'h0;
            wcnt_q    <= 4'h0;
            wr_hit_q  <= 1'h0;
            if (wr_hit_q) wr_req_q <= !wr_req_q;
        end else if (start_c) begin
            ts_q      <= TS_ADDR;
            bc_q      <= 4'h0;
            got_ptr_q <= 1'h0;
            sda_oe_q  <= 1'h0;
        end else begin
            case (ts_q)
                TS_IDLE: begin
                    sda_oe_q <= 1'h0;
                end
                TS_ADDR, TS_WDATA: begin
                    if (scl_rise && bc_q != 4'h8) begin
                        sh_q <= {sh_q[6:0], sda_s};
                        bc_q <= bc_q + 4'h1;
                    end
                    if (byte_end && ts_q == TS_ADDR) begin
                        rw_q     <= sh_q[0];
                        diag_q   <= hit_diag;
                        sda_oe_q <= addr_ok;
                        ts_q     <= addr_ok ? TS_ACK : TS_IDLE;
                    end else if (byte_end && wcnt_q == MAX_WR_BYTES) begin
                        ts_q <= TS_IDLE;
                    end else if (byte_end && !got_ptr_q) begin
                        ptr_q     <= sh_q;
                        got_ptr_q <= 1'h1;
                        sda_oe_q  <= 1'h1;
                        ts_q      <= TS_ACK;
                    end else if (byte_end) begin
                        if (diag_q && ptr_q == CS_OFFSET) begin
                            wr_val_q <= sh_q[SOFT_DIS_BIT];
                            wr_hit_q <= 1'h1;
                        end
                        ptr_q    <= ptr_q + 8'h01;
                        wcnt_q   <= wcnt_q + 4'h1;
                        sda_oe_q <= 1'h1;
                        ts_q     <= TS_ACK;
                    end
                end
                TS_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'h0;
                        bc_q     <= 4'h0;
                        if (rw_q) begin
                            // hold the clock low while the byte is fetched
                            scl_oe_q <= 1'h1;
                            sh_q     <= rd_next;
                            ptr_q    <= ptr_q + 8'h01;
                            ts_q     <= TS_RDATA;
                        end else begin
                            ts_q <= TS_WDATA;
                        end
                    end
                end
                TS_RDATA: begin
                    scl_oe_q <= 1'h0;
                    sda_oe_q <= !sh_q[7];
                    if (scl_fall) begin
                        sh_q <= {sh_q[6:0], 1'h0};
                        bc_q <= bc_q + 4'h1;
                        if (bc_q == 4'h7) begin
                            sda_oe_q <= 1'h0;
                            ts_q     <= TS_RACK;
                        end
                    end
                end
                TS_RACK: begin
                    if (scl_rise) mack_q <= !sda_s;
                    if (scl_fall && mack_q) begin
                        sh_q     <= rd_next;
                        ptr_q    <= ptr_q + 8'h01;
                        bc_q     <= 4'h0;
                        scl_oe_q <= 1'h1;
                        ts_q     <= TS_RDATA;
                    end else if (scl_fall) begin
                        ts_q <= TS_IDLE;
                    end
                end
                default: begin
                    ts_q     <= TS_IDLE;
                    sda_oe_q <= 1'h0;
                end
            endcase
        end
    end

    // open-drain: only ever pull low
    assign scl_out    = 1'h0;
    assign sda_out    = 1'h0;
    assign scl_oe_out = scl_oe_q;
    assign sda_oe_out = sda_oe_q;
endmodule

// ### verification/module_ctl_status_asserts.sv
// assertions on the ports of the module control and status block
`timescale 1ns/1ps
module module_ctl_status_asserts #(
    parameter int unsigned DATA_CYCLES = 200
) (
    input wire logic               ref_clk_in,
    input wire logic               reset_in,
    input wire logic               laser_disable_in,
    input wire logic               fault_detect_in,
    input wire logic               signal_detect_in,
    input wire logic               scl_oe_out,
    input wire logic               laser_enable_out,
    input wire logic               laser_fault_out,
    input wire logic               optical_input_lost_flag_out,
    input wire mcs_pkg::ctl_stat_s status_out
);
    import mcs_pkg::*;
    // --------------------
    // helper counters
    // --------------------
    logic [10:0] sd_q;
    logic        sd_last_q;
    logic [7:0]  flt_q;
    logic [15:0] pwr_q;
    always_ff @(posedge ref_clk_in) sd_last_q <= signal_detect_in;
    // restarts on every change of the light input
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || sd_last_q != signal_detect_in) sd_q <= 11'h000;
        else if (sd_q != 11'h7FF) sd_q <= sd_q + 11'h001;
    end
    // only a fault seen while the laser is lit must latch
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !fault_detect_in) flt_q <= 8'h00;
        else if (flt_q != 8'hFF && (flt_q != 8'h00 || laser_enable_out)) flt_q <= flt_q + 8'h01;
    end
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) pwr_q <= 16'h0000;
        else if (pwr_q != 16'hFFFF) pwr_q <= pwr_q + 16'h0001;
    end
    // --------------------
    // properties
    // --------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    property p_dis_hold; laser_disable_in [*5] |-> !laser_enable_out; endproperty
    a_dis_hold: assert property (p_dis_hold) else $error("laser lit, pin held");
    property p_on;
        $fell(laser_disable_in) && !laser_fault_out && !status_out.soft_dis && !fault_detect_in
            && $past(laser_enable_out, 8) |-> ##[1:6] laser_enable_out;
    endproperty
    a_on: assert property (p_on) else $error("laser not restored");
    property p_soft_off; status_out.soft_dis |-> !laser_enable_out; endproperty
    a_soft_off: assert property (p_soft_off) else $error("lit, soft off");
    property p_fault; flt_q == 8'h78 |-> laser_fault_out; endproperty
    a_fault: assert property (p_fault) else $error("fault pin late");
    property p_fault_stat; $rose(laser_fault_out) |-> ##[0:3] status_out.fault; endproperty
    a_fault_stat: assert property (p_fault_stat) else $error("fault bit late");
    property p_los; sd_q == 11'h3F2 |-> optical_input_lost_flag_out == !signal_detect_in; endproperty
    a_los: assert property (p_los) else $error("loss pin late");
    property p_soft_los;
        $changed(optical_input_lost_flag_out)
            |-> ##[0:3] (status_out.lost == optical_input_lost_flag_out);
    endproperty
    a_soft_los: assert property (p_soft_los) else $error("loss bit late");
    property p_ready; pwr_q > 16'(DATA_CYCLES + 2) |-> status_out.data_ready; endproperty
    a_ready: assert property (p_ready) else $error("data ready late");
    // one link cycle is sixteen core cycles
    property p_stretch; $rose(scl_oe_out) |-> ##8 scl_oe_out ##[6:9] !scl_oe_out; endproperty
    a_stretch: assert property (p_stretch) else $error("stretch length");
    c_fault: cover property ($rose(laser_fault_out));
    c_soft: cover property ($rose(status_out.soft_dis));
    c_stretch: cover property ($rose(scl_oe_out));
endmodule

// ### verification/host_model.sv
// two-wire host controller model on open-drain bus lines
`timescale 1ns/1ps
module host_model (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_oe_out,
    output logic      sda_oe_out
);
    // --------------------
    // bit level
    // --------------------
    localparam int HALF_NS = 1250; // 400 kHz, the fastest allowed
    initial begin
        scl_oe_out = 1'b0;
        sda_oe_out = 1'b0;
    end
    // waits out a stretch, bounded so a stuck line cannot hang
    task automatic scl_rise();
        scl_oe_out = 1'b0;
        for (int n = 0; n < 50 && scl_in !== 1'b1; n++) #160;
        #HALF_NS;
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_oe_out = !b;
        #HALF_NS;
        scl_rise();
        r = sda_in;
        scl_oe_out = 1'b1;
    endtask
    task automatic start();
        sda_oe_out = 1'b0;
        #HALF_NS;
        scl_rise();
        sda_oe_out = 1'b1;
        #HALF_NS;
        scl_oe_out = 1'b1;
    endtask
    task automatic stop();
        sda_oe_out = 1'b1;
        #HALF_NS;
        scl_rise();
        sda_oe_out = 1'b0;
        #20000; // bus free time
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(1'b1, r);
    endtask
    // retries while the device is still committing
    task automatic addr_dev(input logic [7:0] a, output logic ack);
        ack = 1'b0;
        for (int n = 0; n < 3 && !ack; n++) begin
            start();
            send(a, ack);
            if (!ack) stop();
        end
    endtask
endmodule

// ### verification/tb_module_ctl_status.sv
// testbench of the module control and status block
`timescale 1ns/1ps
module tb_module_ctl_status;
    import mcs_pkg::*;
    localparam int unsigned INIT_C = 40;
    localparam int unsigned DATA_C = 200;
    logic      ref_clk_in       = 1'b0;
    logic      link_clk_in      = 1'b0;
    logic      reset_in         = 1'b1;
    logic      laser_disable_in = 1'b0;
    logic      fault_detect_in  = 1'b0;
    logic      signal_detect_in = 1'b1;
    logic      scl_oe, sda_oe, h_scl_oe, h_sda_oe, laser_en, laser_flt, lost, ack;
    logic [7:0] rd;
    ctl_stat_s stat;
    wire logic scl = !(scl_oe | h_scl_oe);
    wire logic sda = !(sda_oe | h_sda_oe);
    int        err_total = 0;
    int        tests_run = 0;
    int        cyc       = 0;
    always #5 ref_clk_in = !ref_clk_in;
    initial #3 forever #80 link_clk_in = !link_clk_in;
    module_ctl_status #(.INIT_CYCLES(INIT_C), .SERIAL_CYCLES(INIT_C), .DATA_CYCLES(DATA_C))
    module_ctl_status_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .link_clk_in(link_clk_in), .laser_disable_in(laser_disable_in),
        .fault_detect_in(fault_detect_in), .signal_detect_in(signal_detect_in),
        .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(),
        .sda_oe_out(sda_oe), .laser_enable_out(laser_en), .laser_fault_out(laser_flt),
        .optical_input_lost_flag_out(lost), .status_out(stat));
    host_model host_model_i (.scl_in(scl), .sda_in(sda), .scl_oe_out(h_scl_oe),
        .sda_oe_out(h_sda_oe));
    // --------------------
    // shared tasks
    // --------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_c(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask
    task automatic wr_cs(input logic [7:0] d);
        host_model_i.addr_dev({DIAG_ADDR, 1'b0}, ack);
        check("wr ack", {7'h00, ack}, 8'h01);
        host_model_i.send(CS_OFFSET, ack);
        host_model_i.send(d, ack);
        check("wr data ack", {7'h00, ack}, 8'h01);
        host_model_i.stop();
    endtask
    task automatic rd_byte(input logic [6:0] dev, output logic [7:0] d);
        host_model_i.addr_dev({dev, 1'b0}, ack);
        host_model_i.send(CS_OFFSET, ack);
        host_model_i.start();
        host_model_i.send({dev, 1'b1}, ack);
        check("rd ack", {7'h00, ack}, 8'h01);
        host_model_i.recv(d);
        host_model_i.stop();
    endtask
    // --------------------
    // scenarios
    // --------------------
    task automatic t_disable();
        wait_c(INIT_C / 2 + 8);
        check("init on", {7'h00, laser_en}, 8'h01);
        laser_disable_in = 1'b1;
        wait_c(5);
        check("hw off", {7'h00, laser_en}, 8'h00);
        laser_disable_in = 1'b0;
        wait_c(6);
        check("hw on", {7'h00, laser_en}, 8'h01);
    endtask
    // only bit 6 of a write may stick
    task automatic t_soft();
        wr_cs(8'hFF);
        wait_c(10);
        check("soft off", {7'h00, laser_en}, 8'h00);
        rd_byte(DIAG_ADDR, rd);
        check("cs byte", rd, 8'h41);
        wr_cs(8'h00);
        wait_c(10);
        check("soft on", {7'h00, laser_en}, 8'h01);
    endtask
    task automatic t_fault();
        fault_detect_in = 1'b1;
        wait_c(120);
        check("fault pin", {6'h00, laser_flt, laser_en}, 8'h02);
        fault_detect_in = 1'b0;
        rd_byte(DIAG_ADDR, rd);
        check("fault bit", rd, 8'h05);
        laser_disable_in = 1'b1;
        wait_c(500);
        laser_disable_in = 1'b0;
        wait_c(10);
        check("short pulse", {7'h00, laser_flt}, 8'h01);
        laser_disable_in = 1'b1;
        wait_c(1100); // held past the clearing time
        laser_disable_in = 1'b0;
        wait_c(10);
        check("fault clr", {7'h00, laser_flt}, 8'h00);
        wait_c(INIT_C / 2 + 5);
        check("reinit on", {7'h00, laser_en}, 8'h01);
    endtask
    task automatic t_los();
        signal_detect_in = 1'b0;
        wait_c(1010);
        check("los set", {6'h00, lost, stat.lost}, 8'h03);
        signal_detect_in = 1'b1;
        wait_c(1010);
        check("los clr", {6'h00, lost, stat.lost}, 8'h00);
    endtask
    task automatic t_bus();
        host_model_i.addr_dev(8'h78, ack);
        check("bad addr", {7'h00, ack}, 8'h00);
        rd_byte(ID_ADDR, rd);
        check("id read", rd, 8'h00);
    endtask
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 95000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        wait_c(10);
        check("rst pins", {5'h00, laser_en, laser_flt, lost}, 8'h01);
        check("rst status", {3'h0, stat}, 8'h00);
        // long enough for the link side to see reset too
        wait_c(60);
        reset_in = 1'b0;
        t_disable();
        t_soft();
        t_fault();
        t_los();
        t_bus();
        complete_run();
    end
endmodule
bind module_ctl_status module_ctl_status_asserts #(.DATA_CYCLES(DATA_CYCLES))
module_ctl_status_asserts_i (.ref_clk_in, .reset_in, .laser_disable_in, .fault_detect_in,
    .signal_detect_in, .scl_oe_out, .laser_enable_out, .laser_fault_out,
    .optical_input_lost_flag_out, .status_out);
